// File: hdl/charger_peak_power_option_ctrl.sv
/*
  Option-register control: comparator forced path-off, shipping discharge,
  low-battery auto wake-up and peak power mode cycle timing.
  Assumes a byte-wide register port fed by the serial host transport, and
  analog status pins that are asynchronous to mclk.
*/
// Operation
// - filter select 11b keeps comparator on with 5 s deglitch.
// - force-off bit set plus comparator trigger turns both input switches off.
// - charger good output goes low when forced shutdown happens.
// - ship discharge bit 1 drives battery negative node discharge.
// - ship discharge bit clears itself after 140 ms.
// - wake bit and low battery apply 128 mA charge up to 30 minutes.
// - battery above minimum ends wake charge and clears wake bit.
// - overload time field selects 1, 2, 10 or 20 ms.
// - overshoot enable lets input current overshoot start peak power mode.
// - undershoot enable lets system voltage undershoot start peak power mode.
// - both peak enables zero keeps peak power mode off.
// - adapter removal clears both peak enables.
// - overload flag shows overload cycle; writing 0 leaves it.
// - relax flag shows relax cycle; writing 0 leaves it.
// - cycle period field selects 5, 10, 20 or 40 ms.
// - second option register is 16 bits at two bytes, reset 2B7h.
// - deglitch only on falling edge; 00b off, 01b 1 us, 10b 2 ms.
`timescale 1ns/10ps
module charger_peak_power_option_ctrl #(
  parameter int TICK_CYCLES = charger_opt_pkg::TICK_CYCLES,
  parameter int DEG_LONG_TICKS = charger_opt_pkg::DEG_LONG_MS,
  parameter int SHIP_TICKS = charger_opt_pkg::SHIP_MS,
  parameter int WAKE_TICKS = charger_opt_pkg::WAKE_MS
) (
  input wire logic mclk,                   // 40 MHz core clock
  input wire logic rstn,                   // synchronous reset, active low
  input wire logic wr_en,                  // register byte write strobe
  input wire logic [7:0] reg_addr,         // register byte address
  input wire logic [7:0] wr_data,          // write data byte
  output logic [7:0] rd_data,              // read data of reg_addr, one cycle later
  input wire logic comparator_out_pin,     // comparator output, low means trip
  input wire logic adapter_present,        // adapter attached
  input wire logic battery_below_minsys,   // battery under minimum system voltage
  input wire logic input_overshoot,        // input current overshoot
  input wire logic sys_undershoot,         // system voltage undershoot
  output logic input_high_switch_on,       // input high-side switch enable
  output logic output_high_switch_on,      // output high-side switch enable
  output logic charger_good_out,           // charger good indication
  output logic battery_sense_neg_node_dis, // discharge path on the negative sense node
  output logic wake_charge_on,             // apply wake-up charge current
  output logic peak_overload_on            // peak power overload phase active
);
  pin_sync_if pins ();
  assign pins.raw = {sys_undershoot, input_overshoot, battery_below_minsys,
                     adapter_present, comparator_out_pin};

  pin_sync u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pins(pins)
  );

  wire cmp_lvl = pins.clean[charger_opt_pkg::PIN_CMP];
  wire adapter_lvl = pins.clean[charger_opt_pkg::PIN_ADAPTER];
  wire below_lvl = pins.clean[charger_opt_pkg::PIN_BELOW];
  wire ovs_lvl = pins.clean[charger_opt_pkg::PIN_OVS];
  wire und_lvl = pins.clean[charger_opt_pkg::PIN_UND];

  function automatic logic [7:0] ovld_ms(input logic [1:0] sel);
    case (sel)
      2'h0: ovld_ms = 8'(charger_opt_pkg::OVLD_MS_0);
      2'h1: ovld_ms = 8'(charger_opt_pkg::OVLD_MS_1);
      2'h2: ovld_ms = 8'(charger_opt_pkg::OVLD_MS_2);
      default: ovld_ms = 8'(charger_opt_pkg::OVLD_MS_3);
    endcase
  endfunction : ovld_ms

  function automatic logic [7:0] period_ms(input logic [1:0] sel);
    case (sel)
      2'h0: period_ms = 8'(charger_opt_pkg::PERIOD_MS_0);
      2'h1: period_ms = 8'(charger_opt_pkg::PERIOD_MS_1);
      2'h2: period_ms = 8'(charger_opt_pkg::PERIOD_MS_2);
      default: period_ms = 8'(charger_opt_pkg::PERIOD_MS_3);
    endcase
  endfunction : period_ms

  // registers
  logic [7:0] opt1_ff;
  logic [15:0] opt2_ff;
  logic [7:0] nxt_opt1;
  logic [15:0] nxt_opt2;
  logic [7:0] rd_data_ff;

  wire wr_opt1 = wr_en && (reg_addr == charger_opt_pkg::ADDR_OPT1);
  wire wr_lo = wr_en && (reg_addr == charger_opt_pkg::ADDR_OPT2_LO);
  wire wr_hi = wr_en && (reg_addr == charger_opt_pkg::ADDR_OPT2_HI);

  wire [1:0] deg_sel = opt1_ff[charger_opt_pkg::OPT1_COMPARATOR_FILTER_SEL +: 2];
  wire force_off_bit = opt1_ff[charger_opt_pkg::OPT1_FORCE_OFF];
  wire ship_bit = opt1_ff[charger_opt_pkg::OPT1_SHIP];
  wire wake_bit = opt1_ff[charger_opt_pkg::OPT1_WAKE];
  wire [1:0] ovld_sel = opt2_ff[8 + charger_opt_pkg::OPT2_OVLD_SEL +: 2];
  wire en_ovs = opt2_ff[8 + charger_opt_pkg::OPT2_EN_OVS];
  wire en_und = opt2_ff[8 + charger_opt_pkg::OPT2_EN_UND];
  wire [1:0] period_sel = opt2_ff[8 + charger_opt_pkg::OPT2_PERIOD_SEL +: 2];

  // 1 ms enable tick
  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  wire tick_wrap = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      tick_ff <= tick_wrap;
    end
  end

  // comparator falling-edge deglitch; rising edges pass at once
  logic [31:0] deg_cnt_ff;
  logic filt_ff;
  logic filt_d_ff;
  wire deg_fast = (deg_sel == 2'h1);
  wire [31:0] deg_limit = deg_fast ? 32'(charger_opt_pkg::DEG_SHORT_CYCLES) :
                          (deg_sel == 2'h2) ? 32'(charger_opt_pkg::DEG_MID_MS) :
                          32'(DEG_LONG_TICKS);
  wire deg_step = deg_fast | tick_ff;
  wire deg_done = (deg_cnt_ff >= deg_limit);
  always_ff @(posedge mclk) begin
    if (!rstn || deg_sel == 2'h0 || cmp_lvl) begin
      deg_cnt_ff <= 32'h0000_0000;
      filt_ff <= 1'b1;
    end else if (deg_done) begin
      filt_ff <= 1'b0;
    end else if (deg_step) begin
      deg_cnt_ff <= deg_cnt_ff + 32'h0000_0001;
    end
  end
  always_ff @(posedge mclk) begin
    filt_d_ff <= rstn ? filt_ff : 1'b1;
  end
  wire cmp_trig = filt_d_ff & ~filt_ff;

  // forced power path off latch, held until software drops the enable
  logic latch_ff;
  always_ff @(posedge mclk) begin
    if (!rstn || !force_off_bit) begin
      latch_ff <= 1'b0;
    end else if (cmp_trig) begin
      latch_ff <= 1'b1;
    end
  end
  wire shut_now = latch_ff | (cmp_trig & force_off_bit);

  // shipping discharge timer
  logic [31:0] ship_cnt_ff;
  wire ship_expire = ship_bit && tick_ff && (ship_cnt_ff == 32'(SHIP_TICKS - 1));
  always_ff @(posedge mclk) begin
    if (!rstn || !ship_bit) begin
      ship_cnt_ff <= 32'h0000_0000;
    end else if (tick_ff) begin
      ship_cnt_ff <= ship_cnt_ff + 32'h0000_0001;
    end
  end

  // auto wake-up charge timer; a full timeout stops the charge but keeps the bit
  logic [31:0] wake_cnt_ff;
  logic wake_on_ff;
  wire wake_time_left = (wake_cnt_ff < 32'(WAKE_TICKS));
  wire wake_run = wake_bit && below_lvl && wake_time_left;
  wire wake_done = wake_on_ff && !below_lvl;
  always_ff @(posedge mclk) begin
    if (!rstn || !wake_bit) begin
      wake_cnt_ff <= 32'h0000_0000;
    end else if (wake_run && tick_ff) begin
      wake_cnt_ff <= wake_cnt_ff + 32'h0000_0001;
    end
  end

  // adapter removal edge
  logic adapter_d_ff;
  always_ff @(posedge mclk) begin
    adapter_d_ff <= rstn ? adapter_lvl : 1'b0;
  end
  wire adapter_gone = adapter_d_ff & ~adapter_lvl;

  // peak power cycle
  charger_opt_pkg::pk_state_type pk_state_ff;
  charger_opt_pkg::pk_state_type nxt_pk_state;
  logic [7:0] pk_cnt_ff;
  logic [7:0] nxt_pk_cnt;
  wire pk_enabled = en_ovs | en_und;
  wire pk_trig = (en_ovs & ovs_lvl) | (en_und & und_lvl);
  wire [7:0] ovld_len = ovld_ms(ovld_sel);
  wire [7:0] period_len = period_ms(period_sel);
  wire no_relax = (ovld_len >= period_len);
  wire [7:0] pk_cnt_inc = pk_cnt_ff + 8'h01;
  wire ovld_end = tick_ff && (pk_cnt_inc >= ovld_len);
  wire period_end = tick_ff && (pk_cnt_inc >= period_len);
  wire ovld_flag_clr = wr_hi && !wr_data[charger_opt_pkg::OPT2_OVLD_FLAG];
  wire relax_flag_clr = wr_hi && !wr_data[charger_opt_pkg::OPT2_RELAX_FLAG];
  wire cycle_again = pk_trig ? 1'b1 : 1'b0;

  always_comb begin
    nxt_pk_state = pk_state_ff;
    nxt_pk_cnt = tick_ff ? pk_cnt_inc : pk_cnt_ff;
    case (pk_state_ff)
      charger_opt_pkg::PK_IDLE: begin
        nxt_pk_cnt = 8'h00;
        if (pk_trig) begin
          nxt_pk_state = charger_opt_pkg::PK_OVLD;
        end
      end
      charger_opt_pkg::PK_OVLD: begin
        if (ovld_flag_clr) begin
          nxt_pk_state = charger_opt_pkg::PK_IDLE;
        end else if (ovld_end && no_relax) begin
          nxt_pk_cnt = 8'h00;
          nxt_pk_state = cycle_again ? charger_opt_pkg::PK_OVLD : charger_opt_pkg::PK_IDLE;
        end else if (ovld_end) begin
          nxt_pk_state = charger_opt_pkg::PK_RELAX;
        end
      end
      charger_opt_pkg::PK_RELAX: begin
        if (relax_flag_clr) begin
          nxt_pk_state = charger_opt_pkg::PK_IDLE;
        end else if (period_end) begin
          nxt_pk_cnt = 8'h00;
          nxt_pk_state = cycle_again ? charger_opt_pkg::PK_OVLD : charger_opt_pkg::PK_IDLE;
        end
      end
      default: begin
        nxt_pk_state = charger_opt_pkg::PK_IDLE;
      end
    endcase
    if (!pk_enabled) begin
      nxt_pk_state = charger_opt_pkg::PK_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pk_state_ff <= charger_opt_pkg::PK_IDLE;
      pk_cnt_ff <= 8'h00;
    end else begin
      pk_state_ff <= nxt_pk_state;
      pk_cnt_ff <= nxt_pk_cnt;
    end
  end

  wire in_ovld = (pk_state_ff == charger_opt_pkg::PK_OVLD);
  wire in_relax = (pk_state_ff == charger_opt_pkg::PK_RELAX);

  // register next values; a host write wins over a hardware clear
  always_comb begin
    nxt_opt1 = opt1_ff;
    if (ship_expire) begin
      nxt_opt1[charger_opt_pkg::OPT1_SHIP] = 1'b0;
    end
    if (wake_done) begin
      nxt_opt1[charger_opt_pkg::OPT1_WAKE] = 1'b0;
    end
    if (wr_opt1) begin
      nxt_opt1 = wr_data;
    end
    nxt_opt2 = opt2_ff;
    if (adapter_gone) begin
      nxt_opt2[8 + charger_opt_pkg::OPT2_EN_OVS] = 1'b0;
      nxt_opt2[8 + charger_opt_pkg::OPT2_EN_UND] = 1'b0;
    end
    if (wr_lo) begin
      nxt_opt2[7:0] = wr_data;
    end
    if (wr_hi) begin
      nxt_opt2[15:8] = wr_data;
    end
    // the cycle flags always mirror the peak state machine
    nxt_opt2[8 + charger_opt_pkg::OPT2_OVLD_FLAG] =
      (nxt_pk_state == charger_opt_pkg::PK_OVLD);
    nxt_opt2[8 + charger_opt_pkg::OPT2_RELAX_FLAG] =
      (nxt_pk_state == charger_opt_pkg::PK_RELAX);
  end

  wire [7:0] rd_mux = (reg_addr == charger_opt_pkg::ADDR_OPT1) ? opt1_ff :
                      (reg_addr == charger_opt_pkg::ADDR_OPT2_LO) ? opt2_ff[7:0] :
                      (reg_addr == charger_opt_pkg::ADDR_OPT2_HI) ? opt2_ff[15:8] : 8'h00;

  logic in_sw_ff;
  logic good_ff;
  logic ship_out_ff;
  logic wake_out_ff;
  logic ovld_out_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      opt1_ff <= charger_opt_pkg::OPT1_RESET;
      opt2_ff <= charger_opt_pkg::OPT2_RESET;
      rd_data_ff <= 8'h00;
      in_sw_ff <= 1'b0;
      good_ff <= 1'b0;
      ship_out_ff <= 1'b0;
      wake_out_ff <= 1'b0;
      wake_on_ff <= 1'b0;
      ovld_out_ff <= 1'b0;
    end else begin
      opt1_ff <= nxt_opt1;
      opt2_ff <= nxt_opt2;
      rd_data_ff <= rd_mux;
      in_sw_ff <= !shut_now;
      good_ff <= adapter_lvl && !shut_now;
      ship_out_ff <= ship_bit && !ship_expire;
      wake_out_ff <= wake_run && !wake_done;
      wake_on_ff <= wake_run;
      ovld_out_ff <= (nxt_pk_state == charger_opt_pkg::PK_OVLD);
    end
  end

  assign rd_data = rd_data_ff;
  assign input_high_switch_on = in_sw_ff;
  assign output_high_switch_on = in_sw_ff;
  assign charger_good_out = good_ff;
  assign battery_sense_neg_node_dis = ship_out_ff;
  assign wake_charge_on = wake_out_ff;
  assign peak_overload_on = ovld_out_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  path_off_a: assert property (cmp_trig && force_off_bit |=> !input_high_switch_on)
    else $error("switches not opened on forced shutdown");
  good_low_a: assert property (cmp_trig && force_off_bit |=> !charger_good_out)
    else $error("charger good not low on forced shutdown");
  ship_drive_a: assert property (ship_bit && !ship_expire |=> battery_sense_neg_node_dis)
    else $error("discharge not driven while ship bit set");
  ship_clear_a: assert property (ship_expire && !wr_opt1 |=> !ship_bit ##1 !battery_sense_neg_node_dis)
    else $error("ship bit not cleared at end of interval");
  wake_clear_a: assert property (wake_done && !wr_opt1 |=> !wake_bit && !wake_charge_on)
    else $error("wake bit not cleared above minimum voltage");
  pk_off_a: assert property (!pk_enabled |=> pk_state_ff == charger_opt_pkg::PK_IDLE)
    else $error("peak mode active with both enables off");
  adapter_clr_a: assert property (adapter_gone && !wr_hi |=> !en_ovs && !en_und)
    else $error("peak enables survive adapter removal");
  ovld_exit_a: assert property (in_ovld && ovld_flag_clr |=> !in_ovld && !peak_overload_on)
    else $error("overload cycle not left on flag write");
  relax_exit_a: assert property (in_relax && relax_flag_clr |=> !in_relax)
    else $error("relax cycle not left on flag write");
  flag_mirror_a: assert property (opt2_ff[8 + charger_opt_pkg::OPT2_OVLD_FLAG] == in_ovld)
    else $error("overload flag does not track state");
  skip_relax_a: assert property (in_ovld && no_relax |=> !in_relax)
    else $error("relax entered though overload exceeds period");

  shut_c: cover property (cmp_trig && force_off_bit);
  ship_c: cover property (ship_expire);
  relax_c: cover property (in_ovld ##1 in_relax);
  wake_c: cover property (wake_done);
endmodule : charger_peak_power_option_ctrl

// File: hdl/charger_opt_pkg.sv
/*
  Constants shared by the option-register control block: byte addresses,
  field positions, reset values and timing figures.
  Assumes a 40 MHz core clock; all times are derived from that rate.
*/
package charger_opt_pkg;
  localparam int MCLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = MCLK_HZ / 1000 * TICK_MS;
  localparam int DEG_SHORT_US = 1;
  localparam int DEG_SHORT_CYCLES = MCLK_HZ / 1_000_000 * DEG_SHORT_US;
  localparam int DEG_MID_MS = 2;
  localparam int DEG_LONG_S = 5;
  localparam int DEG_LONG_MS = DEG_LONG_S * 1000;
  localparam int SHIP_MS = 140;
  localparam int WAKE_MIN = 30;
  localparam int WAKE_MS = WAKE_MIN * 60 * 1000;
  localparam int OVLD_MS_0 = 1;
  localparam int OVLD_MS_1 = 2;
  localparam int OVLD_MS_2 = 10;
  localparam int OVLD_MS_3 = 20;
  localparam int PERIOD_MS_0 = 5;
  localparam int PERIOD_MS_1 = 10;
  localparam int PERIOD_MS_2 = 20;
  localparam int PERIOD_MS_3 = 40;
  localparam int WAKE_CHARGE_MA = 128;

  localparam logic [7:0] ADDR_OPT1 = 8'h30;
  localparam logic [7:0] ADDR_OPT2_LO = 8'h32;
  localparam logic [7:0] ADDR_OPT2_HI = 8'h33;

  // first option register, byte 30h
  localparam int OPT1_CMP_REF = 7;
  localparam int OPT1_CMP_POL = 6;
  localparam int OPT1_COMPARATOR_FILTER_SEL = 4;
  localparam int OPT1_FORCE_OFF = 3;
  localparam int OPT1_SHIP = 1;
  localparam int OPT1_WAKE = 0;
  localparam logic [7:0] OPT1_RESET = 8'h11;

  // second option register high byte, 33h
  localparam int OPT2_OVLD_SEL = 6;
  localparam int OPT2_EN_OVS = 5;
  localparam int OPT2_EN_UND = 4;
  localparam int OPT2_OVLD_FLAG = 3;
  localparam int OPT2_RELAX_FLAG = 2;
  localparam int OPT2_PERIOD_SEL = 0;
  localparam logic [15:0] OPT2_RESET = 16'h02B7;

  // synchronised pin indices
  localparam int PIN_CMP = 0;
  localparam int PIN_ADAPTER = 1;
  localparam int PIN_BELOW = 2;
  localparam int PIN_OVS = 3;
  localparam int PIN_UND = 4;
  localparam int PIN_COUNT = 5;
  localparam logic [4:0] PIN_RESET = 5'h01;

  typedef enum logic [1:0] {PK_IDLE, PK_OVLD, PK_RELAX} pk_state_type;
endpackage : charger_opt_pkg

// File: hdl/pin_sync_if.sv
/*
  Carrier between the pin synchroniser and the control core.
  Assumes raw pins are asynchronous to mclk.
*/
`timescale 1ns/10ps
interface pin_sync_if;
  logic [charger_opt_pkg::PIN_COUNT-1:0] raw;
  logic [charger_opt_pkg::PIN_COUNT-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface : pin_sync_if

// File: hdl/pin_sync.sv
/*
  Three-stage synchroniser for the analog status pins.
  Assumes pins are asynchronous; a change is taken once stages two and three agree.
*/
`timescale 1ns/10ps
module pin_sync (
  input wire logic mclk, // core clock
  input wire logic rstn, // synchronous reset, active low
  pin_sync_if.sync pins  // raw in, clean out
);
  logic [charger_opt_pkg::PIN_COUNT-1:0] s1_ff;
  logic [charger_opt_pkg::PIN_COUNT-1:0] s2_ff;
  logic [charger_opt_pkg::PIN_COUNT-1:0] s3_ff;
  logic [charger_opt_pkg::PIN_COUNT-1:0] clean_ff;

  genvar i;
  generate
    for (i = 0; i < charger_opt_pkg::PIN_COUNT; i++) begin : g_bit
      wire agree = (s2_ff[i] == s3_ff[i]);
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          s1_ff[i] <= charger_opt_pkg::PIN_RESET[i];
          s2_ff[i] <= charger_opt_pkg::PIN_RESET[i];
          s3_ff[i] <= charger_opt_pkg::PIN_RESET[i];
          clean_ff[i] <= charger_opt_pkg::PIN_RESET[i];
        end else begin
          s1_ff[i] <= pins.raw[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (agree) begin
            clean_ff[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate

  assign pins.clean = clean_ff;
endmodule : pin_sync

// File: test/host_model.sv
/*
  Host model: byte register master standing in for the serial host transport.
  Assumes rd_data is registered and follows reg_addr one cycle later.
*/
`timescale 1ns/10ps
module host_model (
  input wire logic mclk,         // core clock
  output logic wr_en,            // write strobe
  output logic [7:0] reg_addr,   // byte address
  output logic [7:0] wr_data,    // write byte
  input wire logic [7:0] rd_data // read byte
);
  initial begin
    wr_en = 1'b0;
    reg_addr = 8'h00;
    wr_data = 8'h00;
  end

  // one-cycle strobe; a 0 written to a cycle flag asks the device to leave that phase
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    wr_en = 1'b1;
    reg_addr = a;
    wr_data = d;
    @(posedge mclk);
    #1;
    wr_en = 1'b0;
    // released data shows the inverse so stale bytes cannot pass for good ones
    wr_data = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    repeat (2) @(posedge mclk);
    #1;
    d = rd_data;
  endtask : rd
endmodule : host_model

// File: test/testbench.sv
/*
  Self-checking bench for the option-register control block.
  Assumes shortened tick counts; every expected time is derived from T.
*/
`timescale 1ns/10ps
module testbench;
  localparam int T = 10;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic cmp = 1'b1;
  logic adapter = 1'b1;
  logic below = 1'b0;
  logic ovs = 1'b0;
  logic und = 1'b0;
  logic in_sw, out_sw, good, dis, wake, pk;
  int fails = 0;
  int num_checks = 0;

  always #12.5 mclk = ~mclk;

  host_model host (.mclk(mclk), .wr_en(wr_en), .reg_addr(reg_addr), .wr_data(wr_data),
    .rd_data(rd_data));

  charger_peak_power_option_ctrl #(.TICK_CYCLES(T), .DEG_LONG_TICKS(3), .SHIP_TICKS(4),
    .WAKE_TICKS(6)) u_dut (.mclk(mclk), .rstn(rstn), .wr_en(wr_en), .reg_addr(reg_addr),
    .wr_data(wr_data), .rd_data(rd_data), .comparator_out_pin(cmp),
    .adapter_present(adapter), .battery_below_minsys(below), .input_overshoot(ovs),
    .sys_undershoot(und), .input_high_switch_on(in_sw), .output_high_switch_on(out_sw),
    .charger_good_out(good), .battery_sense_neg_node_dis(dis), .wake_charge_on(wake),
    .peak_overload_on(pk));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wait_pk(input logic v, input int lim, output int n);
    n = 0;
    while (pk !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_pk

  task automatic t_reset();
    logic [7:0] d;
    host.rd(8'h30, d);
    chk("opt1", d, 8'h11);
    host.rd(8'h32, d);
    chk("opt2_lo", d, 8'hB7);
    host.rd(8'h33, d);
    chk("opt2_hi", d, 8'h02);
    host.rd(8'h31, d);
    chk("unmapped", d, 8'h00);
    chk("switches", 8'({in_sw, out_sw, good, wake, pk}), 8'h1C);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ship();
    logic [7:0] d;
    int n;
    host.wr(8'h30, 8'h13);
    cyc(2);
    chk("dis_on", 8'(dis), 8'h01);
    cyc(2 * T);
    chk("dis_held", 8'(dis), 8'h01);
    n = 0;
    while (dis !== 1'b0 && n < 6 * T) begin
      cyc(1);
      n++;
    end
    chk("dis_off", 8'(dis), 8'h00);
    host.rd(8'h30, d);
    chk("ship_bit", d, 8'h11);
    $display("t_ship done");
  endtask : t_ship

  task automatic t_wake();
    logic [7:0] d;
    below = 1'b1;
    cyc(8);
    chk("wake_on", 8'(wake), 8'h01);
    below = 1'b0;
    cyc(8);
    chk("wake_end", 8'(wake), 8'h00);
    host.rd(8'h30, d);
    chk("wake_bit", d, 8'h10);
    host.wr(8'h30, 8'h11);
    below = 1'b1;
    cyc(8);
    chk("wake_again", 8'(wake), 8'h01);
    cyc(7 * T);
    chk("wake_limit", 8'(wake), 8'h00);
    below = 1'b0;
    host.wr(8'h30, 8'h10);
    $display("t_wake done");
  endtask : t_wake

  task automatic t_force();
    logic [7:0] cfg[8] = '{8'h18, 8'h18, 8'h08, 8'h38, 8'h38, 8'h28, 8'h28, 8'h10};
    int lo[8] = '{60, 20, 200, 15, 80, 5, 60, 80};
    logic trip[8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h30, cfg[i]);
      cyc(4);
      cmp = 1'b0;
      cyc(lo[i]);
      cmp = 1'b1;
      cyc(8);
      chk("path_off", 8'({in_sw, out_sw, good}), 8'({3{~trip[i]}}));
      host.wr(8'h30, 8'h10);
      cyc(4);
      chk("path_back", 8'({in_sw, out_sw, good}), 8'h07);
    end
    $display("t_force done");
  endtask : t_force

  task automatic meas(input logic [7:0] cfg, input int ov, input int pr);
    int n, hi, lo;
    host.wr(8'h33, cfg);
    ovs = 1'b1;
    wait_pk(1'b1, 60, n);
    wait_pk(1'b0, 400, n);
    wait_pk(1'b1, 600, n);
    wait_pk(1'b0, 400, hi);
    wait_pk(1'b1, 600, lo);
    chk("ovld_len", 8'(hi >= ov * T - T && hi <= ov * T + T), 8'h01);
    chk("period", 8'(hi + lo >= pr * T - T && hi + lo <= pr * T + T), 8'h01);
    ovs = 1'b0;
    host.wr(8'h33, 8'h00);
    cyc(3);
    chk("idle", 8'(pk), 8'h00);
  endtask : meas

  task automatic t_peak_times();
    int ovt[4] = '{1, 2, 10, 20};
    int prt[4] = '{5, 10, 20, 40};
    for (int k = 0; k < 4; k++) begin
      meas({k[1:0], 6'b100011}, ovt[k], 40);
      meas({6'b001000, k[1:0]}, 1, prt[k]);
    end
    $display("t_peak_times done");
  endtask : t_peak_times

  task automatic t_peak_flags();
    logic [7:0] d;
    int n;
    host.wr(8'h33, 8'hE3);
    ovs = 1'b1;
    wait_pk(1'b1, 60, n);
    host.rd(8'h33, d);
    chk("ovld_flag", d, 8'hEB);
    // drop the trigger first, else the idle state re-enters overload at once
    ovs = 1'b0;
    cyc(6);
    host.wr(8'h33, 8'hE3);
    cyc(3);
    chk("ovld_left", 8'(pk), 8'h00);
    ovs = 1'b1;
    host.wr(8'h33, 8'h23);
    wait_pk(1'b1, 600, n);
    wait_pk(1'b0, 60, n);
    host.rd(8'h33, d);
    chk("relax_flag", d, 8'h27);
    host.wr(8'h33, 8'h23);
    host.rd(8'h33, d);
    chk("relax_left", 8'(d[2]), 8'h00);
    host.wr(8'h33, 8'hE0);
    wait_pk(1'b1, 600, n);
    wait_pk(1'b0, 300, n);
    chk("no_relax", 8'(n >= 300), 8'h01);
    host.wr(8'h33, 8'h00);
    cyc(3);
    chk("both_off", 8'(pk), 8'h00);
    cyc(100);
    chk("stay_off", 8'(pk), 8'h00);
    ovs = 1'b0;
    und = 1'b1;
    // let the synchronised overshoot level fall before the enable is set
    cyc(6);
    host.wr(8'h33, 8'h20);
    wait_pk(1'b1, 60, n);
    chk("wrong_trig", 8'(n >= 60), 8'h01);
    host.wr(8'h33, 8'h10);
    wait_pk(1'b1, 60, n);
    chk("und_trig", 8'(pk), 8'h01);
    host.wr(8'h33, 8'h30);
    adapter = 1'b0;
    cyc(10);
    host.rd(8'h33, d);
    chk("en_clear", {6'h00, d[5:4]}, 8'h00);
    und = 1'b0;
    adapter = 1'b1;
    $display("t_peak_flags done");
  endtask : t_peak_flags

  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // tests take about 6k cycles; the margin covers the longest peak cycles
  initial begin
    #(25 * 60000);
    fails++;
    results();
  end

  initial begin
    cyc(16);
    rstn = 1'b1;
    cyc(6);
    t_reset();
    t_ship();
    t_wake();
    t_force();
    t_peak_times();
    t_peak_flags();
    results();
  end
endmodule : testbench
